// *** src/hbc_ctrl.sv ***
// Hall commutation, speed measurement, PI loop and complementary PWM.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Six 12-bit PWM outputs in three pairs.
// - PWM switching frequency is 20 kHz.
// - Open loop duty follows potentiometer value.
// - Open and closed loop, potentiometer setpoint.
// - Any Hall level change raises commutation event.
// - Sample all Hall bits, update drive pattern.
// - One phase high side, another low side.
// - Third phase has both switches off.
// - Fixed Hall code to phase drive table.
// - Hall events capture the running timer.
// - Period from edges of selected Hall sensor.
// - Hall period timer runs free.
// - Closed loop PI correction sets duty.
// - PI updated once per selected Hall period.
// - Over-current fault disables all PWM outputs.
// - All PWM outputs low on reset.
// - Software per-output enable mask.
// - Periodic tick schedules background tasks.
module hbc_ctrl
  import hbc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PWM_PERIOD_CYC,
  parameter int unsigned TICK_DIV = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hall_a_input,
  input wire logic hall_b_input,
  input wire logic hall_c_input,
  input wire logic ovc_comp_in,
  input wire logic [11:0] pot_value,
  input wire hbc_mode_type loop_mode,
  input wire hbc_gain_type pi_gain,
  input wire logic [1:0] speed_sensor_sel,
  input wire logic [15:0] speed_scale,
  input wire logic [7:0] dead_cycles,
  input wire logic [5:0] pwm_output_control,
  input wire logic fault_clear,
  output logic [5:0] gate_out,
  output logic fault_r,
  output logic hall_invalid_r,
  output logic [15:0] hall_period_r,
  output logic [15:0] hall_capture_r,
  output logic [11:0] duty_r,
  output logic commutate_r,
  output logic bg_tick_r
);
  // Two-stage synchronisers for the Hall pins and comparator.
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  // Previous synchronised Hall code for change detection.
  logic [2:0] hall_prev_r;
  // Latched Hall code used to pick the drive pattern.
  logic [2:0] hall_code_r;
  // Free running Hall period timer and last selected-edge capture.
  logic [15:0] tmr_r;
  logic [15:0] sel_cap_r;
  // PWM carrier counter.
  logic [15:0] pwm_cnt_r;
  // Drive pattern chosen from the Hall code.
  hbc_drive_type drive_r;
  // PI integrator, kept wide and signed to avoid wrap.
  logic signed [23:0] integ_r;
  // Per-switch dead time counters and raw pwm request.
  logic [7:0] dead_r [6];
  logic [5:0] req_prev_r;
  logic [15:0] tick_cnt_r;
  logic pwm_on;
  logic [5:0] req;
  logic [2:0] hall_now;
  logic [2:0] hall_diff;
  logic sel_edge;

  // Map a Hall code onto a drive pattern; invalid codes drive nothing.
  function automatic hbc_drive_type hall_map(input logic [2:0] code);
    hbc_drive_type d;
    d = '0;
    case (code)
      3'h5: begin
        d.a.lo = 1'b1;
        d.b.hi = 1'b1;
      end
      3'h1: begin
        d.a.lo = 1'b1;
        d.c.hi = 1'b1;
      end
      3'h3: begin
        d.b.lo = 1'b1;
        d.c.hi = 1'b1;
      end
      3'h2: begin
        d.a.hi = 1'b1;
        d.b.lo = 1'b1;
      end
      3'h6: begin
        d.a.hi = 1'b1;
        d.c.lo = 1'b1;
      end
      3'h4: begin
        d.b.hi = 1'b1;
        d.c.lo = 1'b1;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  // Clamp a signed value into the duty range.
  function automatic logic [11:0] clamp_duty(input logic signed [23:0] v);
    if (v < 0) begin
      return 12'h000;
    end else if (v > 24'sh000FFF) begin
      return 12'hFFF;
    end else begin
      return v[11:0];
    end
  endfunction

  assign hall_now = sync2_r[2:0];
  assign hall_diff = hall_now ^ hall_prev_r;
  // Only the chosen sensor's edges close a speed period.
  assign sel_edge = (speed_sensor_sel < 2'h3) &&
                    hall_diff[speed_sensor_sel];

  // Synchronise the asynchronous pins; stage one feeds only stage two.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {ovc_comp_in, hall_c_input, hall_b_input, hall_a_input};
      sync2_r <= sync1_r;
    end
  end

  // Detect Hall changes and relatch the full code on each one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hall_prev_r <= 3'h0;
      hall_code_r <= 3'h0;
      commutate_r <= 1'b0;
    end else begin
      hall_prev_r <= hall_now;
      commutate_r <= |hall_diff;
      if (|hall_diff) begin
        hall_code_r <= {hall_now[0], hall_now[1], hall_now[2]};
      end
    end
  end

  // Drive pattern and invalid flag follow the latched code.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '0;
      hall_invalid_r <= 1'b1;
    end else begin
      drive_r <= hall_map(hall_code_r);
      hall_invalid_r <= (hall_code_r == 3'h0) ||
                        (hall_code_r == 3'h7);
    end
  end

  // Free running timer; it wraps, so differences stay valid modulo 2^16.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= 16'h0000;
    end else begin
      tmr_r <= tmr_r + 16'h0001;
    end
  end

  // Capture the timer on every Hall event and measure the selected period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hall_capture_r <= 16'h0000;
      sel_cap_r <= 16'h0000;
      hall_period_r <= PERIOD_RST;
    end else begin
      if (|hall_diff) begin
        hall_capture_r <= tmr_r;
      end
      if (sel_edge) begin
        sel_cap_r <= tmr_r;
        hall_period_r <= tmr_r - sel_cap_r;
      end
    end
  end

  // Speed loop: open loop copies the pot, closed loop runs a PI step
  // once per selected Hall edge. Speed is scale divided by period, so a
  // divider is avoided by comparing setpoint*period against the scale.
  logic signed [23:0] err;
  logic [27:0] sp_prod;
  always_comb begin
    sp_prod = 28'({pot_value} * {hall_period_r});
    if (sp_prod[27:4] > {8'h00, speed_scale}) begin
      err = 24'sh000100;
    end else begin
      err = -24'sh000100;
    end
    if (sp_prod[27:4] == {8'h00, speed_scale}) begin
      err = 24'sh000000;
    end
  end

  // A fixed error step keeps the loop free of overflow, at the price of
  // slow correction: large speed errors shrink one step per period.
  // Open loop reloads the integrator from the pot, so a change to closed
  // loop starts from the last open-loop duty without a jump.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_r <= 24'sd0;
      duty_r <= DUTY_RST;
    end else if (loop_mode == HBC_OPEN) begin
      integ_r <= $signed({12'h000, pot_value});
      duty_r <= pot_value;
    end else if (sel_edge) begin
      integ_r <= integ_r + (err >>> pi_gain.ki_shift);
      duty_r <= clamp_duty(integ_r +
                (err >>> pi_gain.kp_shift));
    end
  end

  // PWM carrier; duty is scaled from 12 bits onto the period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_r <= 16'h0000;
    end else if (pwm_cnt_r >= 16'(PERIOD_CYC - 1)) begin
      pwm_cnt_r <= 16'h0000;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 16'h0001;
    end
  end

  logic [27:0] duty_cmp;
  assign duty_cmp = 28'({duty_r} * 28'(PERIOD_CYC)) >> DUTY_W;
  assign pwm_on = {12'h000, pwm_cnt_r} < duty_cmp;

  // Complementary chopping: high side carries the PWM, low side is held
  // on. Software control masks each switch individually.
  always_comb begin
    req = {drive_r.a.hi & pwm_on, drive_r.a.lo,
           drive_r.b.hi & pwm_on, drive_r.b.lo,
           drive_r.c.hi & pwm_on, drive_r.c.lo};
    req = req & pwm_output_control;
  end

  // Over-current latch; a new trip wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (sync2_r[3]) begin
      fault_r <= 1'b1;
    end else if (fault_clear) begin
      fault_r <= 1'b0;
    end
  end

  // Dead time: a switch may turn on only after its partner has been off
  // for dead_cycles clocks. Outputs drop at once on a trip.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_out <= GATE_RST;
      req_prev_r <= GATE_RST;
      for (int i = 0; i < 6; i++) begin
        dead_r[i] <= DEAD_RST;
      end
    end else begin
      req_prev_r <= req;
      for (int i = 0; i < 6; i++) begin
        if (gate_out[i ^ 1] || req_prev_r[i ^ 1]) begin
          dead_r[i] <= dead_cycles;
        end else if (dead_r[i] != 8'h00) begin
          dead_r[i] <= dead_r[i] - 8'h01;
        end
        gate_out[i] <= req[i] && !req[i ^ 1] && (dead_r[i] == 8'h00) &&
                       !gate_out[i ^ 1] && !fault_r &&
                       !sync2_r[3];
      end
    end
  end

  // Background tick for averaging and status tasks elsewhere.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 16'h0000;
      bg_tick_r <= 1'b0;
    end else if (tick_cnt_r >= 16'(TICK_DIV - 1)) begin
      tick_cnt_r <= 16'h0000;
      bg_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      bg_tick_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/hbc_pkg.sv ***
// Package of constants and carrier types for the Hall commutation controller.
package hbc_pkg;
  // Clock rate in kHz and PWM switching rate in kHz.
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned PWM_KHZ = 20;
  // Cycles in one PWM period, derived from the two rates.
  localparam int unsigned PWM_PERIOD_CYC = CLK_KHZ / PWM_KHZ;
  // Duty word width in bits.
  localparam int unsigned DUTY_W = 12;
  // Hall period timer width.
  localparam int unsigned TMR_W = 16;
  // Reset values.
  localparam logic [11:0] DUTY_RST = 12'h000;
  localparam logic [5:0] GATE_RST = 6'h00;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [7:0] DEAD_RST = 8'h05;
  // Default background tick divider in cycles.
  localparam int unsigned TICK_CYC = 1000;

  // Drive request for one phase: high and low switch enables.
  typedef struct packed {
    logic hi;
    logic lo;
  } hbc_phase_type;

  // Drive pattern for the three phases, A in the top slot.
  typedef struct packed {
    hbc_phase_type a;
    hbc_phase_type b;
    hbc_phase_type c;
  } hbc_drive_type;

  // Operating mode of the speed loop.
  typedef enum logic {
    HBC_OPEN,
    HBC_CLOSED
  } hbc_mode_type;

  // Gains of the PI loop as shift amounts.
  typedef struct packed {
    logic [3:0] kp_shift;
    logic [3:0] ki_shift;
  } hbc_gain_type;
endpackage

// *** tb/hbc_ctrl_asserts.sv ***
// Port level checks for the Hall commutation controller.
`timescale 1ns/100ps
`default_nettype none
module hbc_ctrl_asserts
  import hbc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hall_a_input,
  input wire logic hall_b_input,
  input wire logic hall_c_input,
  input wire logic ovc_comp_in,
  input wire logic [11:0] pot_value,
  input wire hbc_mode_type loop_mode,
  input wire logic [7:0] dead_cycles,
  input wire logic [5:0] pwm_output_control,
  input wire logic [5:0] gate_out,
  input wire logic fault_r,
  input wire logic hall_invalid_r,
  input wire logic [15:0] hall_capture_r,
  input wire logic [11:0] duty_r,
  input wire logic commutate_r,
  input wire logic bg_tick_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Trip must survive the two sync flops and still land within a cycle.
  sequence s_trip;
    ovc_comp_in [*4];
  endsequence
  // Mask held long enough to flush the gate pipeline.
  sequence s_mask_held;
    $stable(pwm_output_control) ##1 $stable(pwm_output_control)
      ##1 $stable(pwm_output_control);
  endsequence
  property p_trip;
    s_trip |-> fault_r && gate_out == 6'h00;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not off");
  property p_fault;
    fault_r |-> gate_out == 6'h00;
  endproperty
  a_fault: assert property (p_fault) else $error("fault gate");
  property p_bad;
    hall_invalid_r && $past(hall_invalid_r, 3) |-> gate_out == 6'h00;
  endproperty
  a_bad: assert property (p_bad) else $error("bad code gate");
  property p_pair;
    !(gate_out[5] && gate_out[4]) && !(gate_out[3] && gate_out[2])
      && !(gate_out[1] && gate_out[0]);
  endproperty
  a_pair: assert property (p_pair) else $error("pair both on");
  property p_dead;
    $fell(gate_out[5]) && dead_cycles >= 8'h05 |-> !gate_out[4] [*4];
  endproperty
  a_dead: assert property (p_dead) else $error("dead time");
  property p_step;
    $onehot0({gate_out[5], gate_out[3], gate_out[1]})
      && $onehot0({gate_out[4], gate_out[2], gate_out[0]});
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_mask;
    s_mask_held |-> (gate_out & ~pwm_output_control) == 6'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_comm;
    $changed({hall_a_input, hall_b_input, hall_c_input})
      |-> ##[1:4] commutate_r;
  endproperty
  a_comm: assert property (p_comm) else $error("no event");
  property p_cap;
    commutate_r |-> $changed(hall_capture_r);
  endproperty
  a_cap: assert property (p_cap) else $error("no capture");
  property p_open;
    loop_mode == HBC_OPEN |=> duty_r == $past(pot_value);
  endproperty
  a_open: assert property (p_open) else $error("open duty");
  // Cycles since the last tick; a counter avoids a long unrolled delay.
  int unsigned tick_gap;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap <= 0;
    end else if (bg_tick_r) begin
      tick_gap <= 1;
    end else begin
      tick_gap <= tick_gap + 1;
    end
  end
  property p_tick;
    bg_tick_r |-> tick_gap == TICK_DIV;
  endproperty
  a_tick: assert property (p_tick) else $error("tick rate");
  property p_rst;
    $rose(rst_n) |-> gate_out == 6'h00 && !fault_r;
  endproperty
  a_rst: assert property (p_rst) else $error("reset gate");
endmodule
bind hbc_ctrl hbc_ctrl_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.clk, .rst_n,
  .hall_a_input, .hall_b_input, .hall_c_input, .ovc_comp_in, .pot_value,
  .loop_mode, .dead_cycles, .pwm_output_control, .gate_out, .fault_r,
  .hall_invalid_r, .hall_capture_r, .duty_r, .commutate_r, .bg_tick_r);
`default_nettype wire

// *** tb/hbc_hall_model.sv ***
// Hall sensor model of a rotor turning at a steady rate.
`timescale 1ns/100ps
`default_nettype none
module hbc_hall_model #(
  parameter int STEP = 40
) (
  input wire logic clk,
  input wire logic run,
  input wire logic bad,
  output logic [2:0] code
);
  // Forward rotation order; one sensor flips per step.
  localparam logic [2:0] SEQ [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  int cnt = 0;
  int idx = 0;
  // Sensors move off the sampling edge, so no race with the design.
  always @(negedge clk) begin
    if (run) begin
      cnt = cnt + 1;
    end
    if (cnt >= STEP) begin
      cnt = 0;
      idx = (idx + 1) % 6;
    end
  end
  // A broken sensor harness reads as all ones.
  assign code = bad ? 3'h7 : SEQ[idx];
endmodule
`default_nettype wire

// *** tb/tb_hbc_ctrl.sv ***
// Self-checking bench for the Hall commutation controller.
`timescale 1ns/100ps
`default_nettype none
module tb_hbc_ctrl;
  import hbc_pkg::*;
  localparam int STEP = 40;
  logic clk = 0, rst_n = 0, ovc = 0, clr = 0, run = 0, bad = 0;
  logic [11:0] pot = 12'hFFF;
  hbc_mode_type mode = HBC_OPEN;
  logic [5:0] mask = 6'h3F, seen, want;
  logic [2:0] code;
  logic [5:0] gate;
  logic flt, inv, com, tick;
  logic [15:0] per, cap, cap0;
  logic [11:0] duty, d0;
  int n_fail = 0, total_checks = 0, n, n_exp;
  hbc_hall_model #(.STEP(STEP)) u_hall (.clk(clk), .run(run), .bad(bad),
    .code(code));
  hbc_ctrl #(.TICK_DIV(10)) dut (.clk(clk), .rst_n(rst_n),
    .hall_a_input(code[2]), .hall_b_input(code[1]), .hall_c_input(code[0]),
    .ovc_comp_in(ovc), .pot_value(pot), .loop_mode(mode),
    .pi_gain(8'h21), .speed_sensor_sel(2'h0), .speed_scale(16'h0400),
    .dead_cycles(8'h05), .pwm_output_control(mask), .fault_clear(clr),
    .gate_out(gate), .fault_r(flt), .hall_invalid_r(inv),
    .hall_period_r(per), .hall_capture_r(cap), .duty_r(duty),
    .commutate_r(com), .bg_tick_r(tick));
  // Free running 10 MHz clock.
  initial begin
    forever #50 clk = ~clk;
  end
  // Reference drive table, bits {AH,AL,BH,BL,CH,CL}.
  function automatic logic [5:0] exp_gate(logic [2:0] c);
    case (c)
      3'h5: return 6'h18;
      3'h1: return 6'h12;
      3'h3: return 6'h06;
      3'h2: return 6'h24;
      3'h6: return 6'h21;
      3'h4: return 6'h09;
      default: return 6'h00;
    endcase
  endfunction
  task automatic cmp_gate(string what, logic [5:0] exp, logic [5:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cmp_word(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    #(100 * 20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32));
    repeat (10) @(negedge clk);
    rst_n = 1;
    run = 1;
    // Two open loop turns, the second with low sides masked, then closed.
    for (int i = 0; i < 18; i++) begin
      @(code);
      seen = 6'h00;
      repeat (10) @(negedge clk);
      d0 = duty;
      if (i > 0) cmp_word("capture step", 16'(STEP), cap - cap0);
      cap0 = cap;
      repeat (STEP - 14) begin
        seen = seen | gate;
        @(negedge clk);
      end
      want = exp_gate(code) & mask;
      cmp_gate("gate", want, seen);
      if (i >= 12) cmp_word("duty hold", 16'(d0), 16'(duty));
      if (i == 17) cmp_word("pi duty", 16'h0FFF, 16'(duty));
      if (i == 5) mask = 6'h2A;
      if (i == 11) begin
        mask = 6'h3F;
        mode = HBC_CLOSED;
        cmp_word("period", 16'(3 * STEP), per);
      end
    end
    run = 0;
    mode = HBC_OPEN;
    bad = 1;
    repeat (10) @(negedge clk);
    cmp_gate("bad gate", 6'h00, gate);
    cmp_word("invalid", 16'h0001, 16'(inv));
    bad = 0;
    // High side on time over one full PWM period at pot zero, then three random settings.
    for (int i = 0; i < 4; i++) begin
      pot = (i == 0) ? 12'h000 : 12'($urandom_range(4095));
      repeat (12) @(negedge clk);
      n = 0;
      repeat (500) begin
        n += int'((gate & 6'h2A) != 6'h00);
        @(negedge clk);
      end
      n_exp = pot * 500 / 4096;
      cmp_word("on cycles", 16'(n_exp), 16'(n));
      cmp_word("duty", 16'(pot), 16'(duty));
    end
    // Trip wins over clear while the comparator is still high.
    pot = 12'hFFF;
    ovc = 1;
    clr = 1;
    repeat (5) @(negedge clk);
    cmp_word("fault", 16'h0001, 16'(flt));
    cmp_gate("trip gate", 6'h00, gate);
    ovc = 0;
    repeat (5) @(negedge clk);
    cmp_word("cleared", 16'h0000, 16'(flt));
    clr = 0;
    repeat (20) @(negedge clk);
    rst_n = 0;
    @(negedge clk);
    cmp_gate("reset gate", 6'h00, gate);
    rst_n = 1;
    repeat (5) @(negedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
